// ### hw/tsc_pkg.sv
// Shared constants and types for the touch converter serial control block
package tsc_pkg;

    // ==========================================================
    // Command framing and timing, counted in serial clock edges
    // ==========================================================
    localparam logic [3:0]  TSC_ACQ_FIRST_FALL = 4'h5;    // Tracking opens on this falling edge
    localparam logic [3:0]  TSC_CMD_DONE_FALL  = 4'h8;    // Command complete, conversion starts
    localparam logic [3:0]  TSC_OVERLAP_BITS   = 4'h6;    // Result bits out before a new start is seen
    localparam logic [3:0]  TSC_LEN_12         = 4'hC;    // Decisions in full resolution
    localparam logic [3:0]  TSC_LEN_8          = 4'h8;    // Decisions in reduced resolution
    localparam int          TSC_RES_BITS       = 12;
    localparam int          TSC_FIFO_DEPTH     = 8;

    // ==========================================================
    // Field codes and reset values
    // ==========================================================
    localparam logic [1:0]  TSC_PD_AUTO        = 2'h0;    // Off between conversions, pen detect on
    localparam logic [2:0]  TSC_CHAN_Y         = 3'h1;    // Y position, Y drivers on
    localparam logic [2:0]  TSC_CHAN_X         = 3'h5;    // X position, X drivers on
    localparam logic [7:0]  TSC_CMD_RST        = 8'h00;
    localparam logic [11:0] TSC_MSB_MASK       = 12'h800;
    localparam logic [11:0] TSC_CODE_RST       = 12'h000;
    localparam logic [3:0]  TSC_CNT_RST        = 4'h0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic       start;
        logic [2:0] chan_addr;
        logic       mode8;
        logic       reference_mode_sel;
        logic       power_sel_hi;
        logic       power_sel_lo;
    } tsc_cmd_t;

    typedef struct packed {
        logic xp;
        logic xn;
        logic yp;
        logic yn;
    } tsc_sw_t;

    typedef struct packed {
        logic [2:0]              chan_addr;
        logic                    mode8;
        logic [TSC_RES_BITS-1:0] code;
    } tsc_res_t;

    typedef enum logic {
        TSC_CM_HUNT = 1'b0,
        TSC_CM_TAKE = 1'b1
    } tsc_cm_state_t;

    typedef enum logic [1:0] {
        TSC_CV_IDLE  = 2'b00,
        TSC_CV_BUSY  = 2'b01,
        TSC_CV_SHIFT = 2'b11
    } tsc_cv_state_t;

endpackage

// ### hw/tsc_fifo.sv
// Result buffer with valid and ready on both sides
`timescale 1ns/1ps
module tsc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Fill side
    input  wire logic                   in_valid_i,
    output logic                        in_ready_o,
    input  wire logic [WIDTH-1:0]       in_data_i,
    // Drain side
    output logic                        out_valid_o,
    input  wire logic                   out_ready_i,
    output logic [WIDTH-1:0]            out_data_o,
    // Fill level
    output logic [$clog2(DEPTH):0]      count_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    wire              push_w = in_valid_i & in_ready_o;
    wire              pop_w  = out_valid_o & out_ready_i;

    // Extra pointer bit separates full from empty
    assign count_o     = wr_ptr_r - rd_ptr_r;
    assign in_ready_o  = (count_o != DEPTH[AW:0]);
    assign out_valid_o = (count_o != '0);
    assign out_data_o  = mem[rd_ptr_r[AW-1:0]];

    // Pointers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push_w)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop_w)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    // Storage, no reset needed on data
    always_ff @(posedge clk_i)
    begin
        if (push_w)
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
    end

endmodule

// ### hw/tsc_serial_ctrl.sv
// Serial command framing and conversion sequencer for a touch-screen converter
//
// Function
// - first high bit after select is start; ignored here while the result buffer has no free slot
// - shift one input bit per rising edge
// - leading zeros before start have no effect
// - output changes on falling edge, MSB first
// - busy high one period after command
// - one decision per falling edge, twelve bits
// - select high floats busy and data out
// - conversion begins at falling edge after bit eight
// - new start accepted after sixth result bit
// - running conversion always completes first
// - back to back conversions every fifteen clocks
// - reduced resolution ends four clocks sooner
// - decode start, address, mode, reference, power
// - power codes set converter and pen detect
// - power-down only after conversion, command restores
// - reset holds power field zero, output zero
// - drivers on at acquisition, single-ended opens them
// - track from fifth to eighth falling edge
// - select rising aborts and powers down
`timescale 1ns/1ps
module tsc_serial_ctrl #(
    parameter int FIFO_DEPTH = tsc_pkg::TSC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Serial port pins
    input  wire logic              host_serial_clock_i,
    input  wire logic              cs_n_i,
    input  wire logic              din_i,
    output logic                   dout_o,
    output logic                   dout_oe_n_o,
    output logic                   busy_o,
    output logic                   busy_oe_n_o,
    // Analog front end
    input  wire logic              comp_i,
    output logic [11:0]            sar_trial_o,
    output logic [2:0]             chan_sel_o,
    output logic                   ref_diff_o,
    output logic                   track_o,
    output logic                   adc_power_o,
    output tsc_pkg::tsc_sw_t       drv_o,
    output logic                   touch_irq_en_o,
    // Result stream
    output logic                   res_valid_o,
    input  wire logic              res_ready_i,
    output tsc_pkg::tsc_res_t      res_data_o
);
    import tsc_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    // ==========================================================
    // Reset release and serial edge detection
    // ==========================================================
    logic [1:0]     rst_sync_r;
    logic           rst_n;
    logic           sclk_q_r;
    logic           cs_low;
    logic           sclk_rise;
    logic           sclk_fall;

    // Release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign rst_n = rst_sync_r[1];

    // Serial clock history, pins are synchronous to clk_i
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            sclk_q_r <= 1'b0;
        else
            sclk_q_r <= host_serial_clock_i;
    end

    // Edges only count while the port is selected
    assign cs_low    = ~cs_n_i;
    assign sclk_rise = cs_low & host_serial_clock_i & ~sclk_q_r;
    assign sclk_fall = cs_low & ~host_serial_clock_i & sclk_q_r;

    // ==========================================================
    // Command framing
    // ==========================================================
    tsc_cm_state_t  cm_state_r;
    tsc_cm_state_t  cm_state_nxt;
    logic [7:0]     cmd_sh_r;
    logic [7:0]     cmd_sh_nxt;
    logic [3:0]     cmd_fall_r;
    logic [3:0]     cmd_fall_nxt;
    logic [3:0]     cmd_fall_inc;
    tsc_cv_state_t  cv_state_r;
    logic [3:0]     out_cnt_r;
    logic [CW-1:0]  fifo_count;
    logic           in_flight;
    logic           room_ok;
    logic           overlap_ok;
    logic           start_ok;
    logic           cmd_done;
    logic           acq_open;
    tsc_cmd_t       new_cmd;

    // A new start needs the previous result past its sixth bit
    // and a free slot, counting the result still in flight
    assign in_flight    = (cv_state_r != TSC_CV_IDLE);
    assign room_ok      = ({1'b0, fifo_count} + {{CW{1'b0}}, in_flight}) < FIFO_DEPTH[CW:0];
    assign overlap_ok   = ~in_flight | ((cv_state_r == TSC_CV_SHIFT) & (out_cnt_r >= TSC_OVERLAP_BITS));
    assign start_ok     = (cm_state_r == TSC_CM_HUNT) & sclk_rise & din_i & overlap_ok & room_ok;
    assign cmd_fall_inc = cmd_fall_r + 4'h1;
    assign cmd_done     = (cm_state_r == TSC_CM_TAKE) & sclk_fall & (cmd_fall_inc == TSC_CMD_DONE_FALL);
    assign acq_open     = (cm_state_r == TSC_CM_TAKE) & sclk_fall & (cmd_fall_inc == TSC_ACQ_FIRST_FALL);
    assign new_cmd      = tsc_cmd_t'(cmd_sh_r);

    // Framing next state
    always_comb
    begin
        cm_state_nxt = cm_state_r;
        cmd_sh_nxt   = cmd_sh_r;
        cmd_fall_nxt = cmd_fall_r;
        if (sclk_rise)
            cmd_sh_nxt = {cmd_sh_r[6:0], din_i};
        if (!cs_low)
        begin
            cm_state_nxt = TSC_CM_HUNT;
            cmd_fall_nxt = TSC_CNT_RST;
        end
        else
        begin
            unique case (cm_state_r)
                TSC_CM_HUNT:
                begin
                    if (start_ok)
                    begin
                        cm_state_nxt = TSC_CM_TAKE;
                        cmd_fall_nxt = TSC_CNT_RST;
                    end
                end
                TSC_CM_TAKE:
                begin
                    if (sclk_fall)
                        cmd_fall_nxt = cmd_fall_inc;
                    if (cmd_done)
                        cm_state_nxt = TSC_CM_HUNT;
                end
            endcase
        end
    end

    // Framing registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cm_state_r <= TSC_CM_HUNT;
            cmd_sh_r   <= TSC_CMD_RST;
            cmd_fall_r <= TSC_CNT_RST;
        end
        else
        begin
            cm_state_r <= cm_state_nxt;
            cmd_sh_r   <= cmd_sh_nxt;
            cmd_fall_r <= cmd_fall_nxt;
        end
    end

    // ==========================================================
    // Successive approximation and result shifting
    // ==========================================================
    tsc_cv_state_t  cv_state_nxt;
    tsc_cmd_t       cur_cmd_r;
    logic [3:0]     out_cnt_nxt;
    logic [3:0]     conv_len;
    logic [11:0]    sar_r;
    logic [11:0]    sar_nxt;
    logic [11:0]    sar_dec;
    logic [11:0]    mask_r;
    logic [11:0]    mask_nxt;
    logic [11:0]    trial_r;
    logic [11:0]    trial_nxt;
    logic           dout_r;
    logic           dout_nxt;
    logic           busy_r;
    logic           busy_nxt;
    logic           conv_end;
    logic           push;
    logic           fifo_in_ready;

    assign conv_len = cur_cmd_r.mode8 ? TSC_LEN_8 : TSC_LEN_12;
    // Decided bit kept when the comparator says input is above trial
    assign sar_dec  = comp_i ? (sar_r | mask_r) : sar_r;
    assign conv_end = (cv_state_r == TSC_CV_SHIFT) & sclk_fall & (out_cnt_r == conv_len);
    assign push     = conv_end;

    // Conversion next state
    always_comb
    begin
        cv_state_nxt = cv_state_r;
        out_cnt_nxt  = out_cnt_r;
        sar_nxt      = sar_r;
        mask_nxt     = mask_r;
        trial_nxt    = trial_r;
        dout_nxt     = dout_r;
        busy_nxt     = busy_r;
        if (!cs_low)
        begin
            cv_state_nxt = TSC_CV_IDLE;
            out_cnt_nxt  = TSC_CNT_RST;
            sar_nxt      = TSC_CODE_RST;
            mask_nxt     = TSC_CODE_RST;
            trial_nxt    = TSC_CODE_RST;
            dout_nxt     = 1'b0;
            busy_nxt     = 1'b0;
        end
        else if (sclk_fall)
        begin
            unique case (cv_state_r)
                TSC_CV_IDLE:
                begin
                    if (cmd_done)
                    begin
                        cv_state_nxt = TSC_CV_BUSY;
                        busy_nxt     = 1'b1;
                        out_cnt_nxt  = TSC_CNT_RST;
                        sar_nxt      = TSC_CODE_RST;
                        mask_nxt     = TSC_MSB_MASK;
                        trial_nxt    = TSC_MSB_MASK;
                    end
                end
                TSC_CV_BUSY, TSC_CV_SHIFT:
                begin
                    busy_nxt = 1'b0;
                    if (conv_end)
                    begin
                        cv_state_nxt = TSC_CV_IDLE;
                        dout_nxt     = 1'b0;
                        mask_nxt     = TSC_CODE_RST;
                        trial_nxt    = TSC_CODE_RST;
                    end
                    else
                    begin
                        cv_state_nxt = TSC_CV_SHIFT;
                        dout_nxt     = comp_i;
                        sar_nxt      = sar_dec;
                        mask_nxt     = mask_r >> 1;
                        trial_nxt    = sar_dec | (mask_r >> 1);
                        out_cnt_nxt  = out_cnt_r + 4'h1;
                    end
                end
                default:
                begin
                    cv_state_nxt = TSC_CV_IDLE;
                end
            endcase
        end
    end

    // Conversion registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cv_state_r <= TSC_CV_IDLE;
            out_cnt_r  <= TSC_CNT_RST;
            sar_r      <= TSC_CODE_RST;
            mask_r     <= TSC_CODE_RST;
            trial_r    <= TSC_CODE_RST;
            dout_r     <= 1'b0;
            busy_r     <= 1'b0;
        end
        else
        begin
            cv_state_r <= cv_state_nxt;
            out_cnt_r  <= out_cnt_nxt;
            sar_r      <= sar_nxt;
            mask_r     <= mask_nxt;
            trial_r    <= trial_nxt;
            dout_r     <= dout_nxt;
            busy_r     <= busy_nxt;
        end
    end

    // Command held for the whole conversion; power field resets to zero
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            cur_cmd_r <= tsc_cmd_t'(TSC_CMD_RST);
        else if (cmd_done)
            cur_cmd_r <= new_cmd;
    end

    // ==========================================================
    // Touch drivers, tracking and power
    // ==========================================================
    logic           track_r;
    logic           pwr_on_r;
    logic [2:0]     acq_chan_r;
    tsc_sw_t        drv_r;
    tsc_sw_t        drv_sel;
    logic [2:0]     acq_chan;
    logic           keep_on;

    // Address bits sit low in the partial command at the fifth falling
    assign acq_chan = cmd_sh_r[3:1];
    assign drv_sel.xp = (acq_chan == TSC_CHAN_X);
    assign drv_sel.xn = (acq_chan == TSC_CHAN_X);
    assign drv_sel.yp = (acq_chan == TSC_CHAN_Y);
    assign drv_sel.yn = (acq_chan == TSC_CHAN_Y);
    assign keep_on    = ({cur_cmd_r.power_sel_hi, cur_cmd_r.power_sel_lo} != TSC_PD_AUTO);

    // Tracking window and driver switches
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            track_r    <= 1'b0;
            drv_r      <= '0;
            acq_chan_r <= 3'h0;
        end
        else if (!cs_low)
        begin
            track_r <= 1'b0;
            drv_r   <= '0;
        end
        else if (acq_open)
        begin
            track_r    <= 1'b1;
            drv_r      <= drv_sel;
            acq_chan_r <= acq_chan;
        end
        else if (cmd_done)
        begin
            track_r <= 1'b0;
            if (new_cmd.reference_mode_sel)
                drv_r <= '0;
        end
        // Keep drivers that an overlapped command has just switched on
        else if (conv_end & ~track_r)
            drv_r <= '0;
    end

    // Power state follows the command only once its conversion ends
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pwr_on_r <= 1'b0;
        else if (!cs_low)
            pwr_on_r <= 1'b0;
        else if (start_ok)
            pwr_on_r <= 1'b1;
        // power-down after conversion end
        // An overlapped command already being taken keeps power up
        else if (conv_end)
            pwr_on_r <= keep_on | (cm_state_r == TSC_CM_TAKE);
    end

    // ==========================================================
    // Result buffer
    // ==========================================================
    tsc_res_t       res_in;

    assign res_in.chan_addr = cur_cmd_r.chan_addr;
    assign res_in.mode8     = cur_cmd_r.mode8;
    assign res_in.code      = sar_r;

    // Slot reserved at start, so a push never meets a full buffer
    tsc_fifo #(
        .WIDTH ($bits(tsc_res_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_res_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (res_in),
        .out_valid_o (res_valid_o),
        .out_ready_i (res_ready_i),
        .out_data_o  (res_data_o),
        .count_o     (fifo_count)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    // float outputs while deselected
    assign dout_oe_n_o    = cs_n_i;
    assign busy_oe_n_o    = cs_n_i;
    assign dout_o         = dout_r;
    assign busy_o         = busy_r;
    assign sar_trial_o    = trial_r;
    assign chan_sel_o     = track_r ? acq_chan_r : cur_cmd_r.chan_addr;
    assign ref_diff_o     = ~cur_cmd_r.reference_mode_sel;
    assign track_o        = track_r;
    assign adc_power_o    = pwr_on_r;
    assign drv_o          = drv_r;
    // pen detect only in auto mode
    assign touch_irq_en_o = ~keep_on & ~pwr_on_r & fifo_in_ready;

endmodule

// ### bench/tsc_serial_ctrl_properties.sv
// Port-level checks for the touch converter serial control block
`timescale 1ns/1ps
module tsc_serial_ctrl_properties
    import tsc_pkg::*;
#(
    parameter int FIFO_DEPTH = TSC_FIFO_DEPTH
) (
    // Everything the top module shows at its ports
    input wire logic              clk_i, rst_n_i, host_serial_clock_i, cs_n_i, din_i, dout_o, dout_oe_n_o,
    input wire logic              busy_o, busy_oe_n_o, comp_i, ref_diff_o, track_o, adc_power_o,
    input wire logic              touch_irq_en_o, res_valid_o, res_ready_i,
    input wire logic [11:0]       sar_trial_o,
    input wire logic [2:0]        chan_sel_o,
    input wire tsc_pkg::tsc_sw_t  drv_o,
    input wire tsc_pkg::tsc_res_t res_data_o
);
    // ==========================================================
    // Serial edge history and expected switch pattern
    // ==========================================================
    logic       sclk_r;
    wire        fall    = sclk_r & ~host_serial_clock_i;
    wire  [3:0] drv_exp = (chan_sel_o == TSC_CHAN_Y) ? 4'h3 : ((chan_sel_o == TSC_CHAN_X) ? 4'hC : 4'h0);

    // Previous serial clock level, parked low in reset like the design
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            sclk_r <= 1'b0;
        else
            sclk_r <= host_serial_clock_i;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Select low for two samples, so select edges are not blamed on the clock
    sequence s_selected;
        !cs_n_i && $past(!cs_n_i);
    endsequence
    sequence s_track_end;
        $fell(track_o) && !cs_n_i;
    endsequence

    a_oe_follow_cs: assert property (dout_oe_n_o == cs_n_i && busy_oe_n_o == cs_n_i)
        else $error("output enable does not follow select");
    a_dout_on_fall: assert property ($changed(dout_o) ##0 s_selected |-> $past(fall))
        else $error("data out moved away from a falling serial edge");
    a_busy_rise_fall: assert property ($rose(busy_o) ##0 s_selected |-> $past(fall))
        else $error("busy rose away from a falling serial edge");
    a_busy_one_period: assert property (busy_o && $past(busy_o) && fall && !cs_n_i |=> !busy_o)
        else $error("busy longer than one serial period");
    a_track_to_busy: assert property (s_track_end |-> $rose(busy_o))
        else $error("conversion did not start as tracking ended");
    a_track_on_fall: assert property ($rose(track_o) |-> $past(fall))
        else $error("tracking opened away from a falling edge");
    a_drv_map: assert property (track_o |-> drv_o == drv_exp)
        else $error("touch switches wrong for tracked address");
    a_single_open: assert property (busy_o |-> (ref_diff_o ? $stable(drv_o) : drv_o == 4'h0))
        else $error("touch switches wrong at conversion start");
    a_abort_on_cs: assert property ($rose(cs_n_i) |=> !busy_o && !track_o && !adc_power_o && !dout_o)
        else $error("select high did not abort");
    a_idle_dout_zero: assert property (!adc_power_o |-> !dout_o)
        else $error("data out not zero while powered down");
    a_irq_powered: assert property (touch_irq_en_o |-> !adc_power_o)
        else $error("pen detect enabled while converter powered");
endmodule

bind tsc_serial_ctrl tsc_serial_ctrl_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .host_serial_clock_i(host_serial_clock_i), .cs_n_i(cs_n_i),
    .din_i(din_i), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .busy_o(busy_o), .busy_oe_n_o(busy_oe_n_o),
    .comp_i(comp_i), .ref_diff_o(ref_diff_o), .track_o(track_o), .adc_power_o(adc_power_o),
    .touch_irq_en_o(touch_irq_en_o), .res_valid_o(res_valid_o), .res_ready_i(res_ready_i),
    .sar_trial_o(sar_trial_o), .chan_sel_o(chan_sel_o), .drv_o(drv_o), .res_data_o(res_data_o)
);

// ### bench/tsc_host_model.sv
// Host serial master model: select, clock and data in, result bits out
`timescale 1ns/1ps
module tsc_host_model #(
    parameter int HALF = 32
) (
    // Clock and serial pins
    input  wire logic clk_i,
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      din_o
);
    logic [31:0] rx;

    // Idle: select high, serial clock stands low
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
        rx     = 32'h0;
    end

    // Select low opens a frame
    task automatic open_frame();
        @(negedge clk_i);
        cs_n_o = 1'b0;
        rx     = 32'h0;
    endtask

    // period 64 cycles, under 2 MHz
    // frames end well inside droop limit
    task automatic shift(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge clk_i);
            sclk_o = 1'b0;
            din_o  = v[i];
            repeat (HALF) @(negedge clk_i);
            rx     = {rx[30:0], dout_i};
            sclk_o = 1'b1;
            repeat (HALF - 1) @(negedge clk_i);
        end
        @(negedge clk_i);
        sclk_o = 1'b0;
        repeat (HALF) @(negedge clk_i);
    endtask

    // Select high ends the frame; data line flips so stale levels are not trusted
    task automatic close_frame();
        @(negedge clk_i);
        cs_n_o = 1'b1;
        din_o  = ~din_o;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the touch converter serial control block
`timescale 1ns/1ps
module testbench;
    import tsc_pkg::*;
    // ==========================================================
    // Signals and stimulus tables
    // ==========================================================
    logic        clk, rst_n, res_ready, sclk, cs_n, din, dout, dout_oe_n, busy, busy_oe_n;
    logic        track, adc_power, irq_en, ref_diff, res_valid;
    logic [11:0] trial, v;
    logic [2:0]  chan_sel;
    tsc_sw_t     drv;
    tsc_res_t    res;
    int          mismatches, n_checks, pops, p0;
    logic [7:0]  cmds [4] = '{8'h90, 8'hDD, 8'hA3, 8'h86};
    logic [11:0] vals [4] = '{12'hABC, 12'h5A7, 12'h001, 12'hFFF};
    // Ideal comparator against the analog level v
    wire         comp = (v >= trial);

    initial clk = 1'b0;
    always #4 clk = ~clk;

    tsc_serial_ctrl DUT (
        .clk_i(clk), .rst_n_i(rst_n), .host_serial_clock_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .dout_o(dout), .dout_oe_n_o(dout_oe_n), .busy_o(busy), .busy_oe_n_o(busy_oe_n), .comp_i(comp),
        .sar_trial_o(trial), .chan_sel_o(chan_sel), .ref_diff_o(ref_diff), .track_o(track),
        .adc_power_o(adc_power), .drv_o(drv), .touch_irq_en_o(irq_en), .res_valid_o(res_valid),
        .res_ready_i(res_ready), .res_data_o(res)
    );
    tsc_host_model host (.clk_i(clk), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

    // Count results taken from the buffer
    always @(posedge clk)
        if (res_valid === 1'b1 && res_ready === 1'b1)
            pops <= pops + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Result bits seen in the two trailing bytes
    function automatic logic [15:0] rx_exp(input logic [7:0] cmd, input logic [11:0] a);
        return cmd[3] ? {1'b0, a[11:4], 7'h00} : {1'b0, a, 3'h0};
    endfunction

    // Frame left open so levels can be checked before select rises
    task automatic convert(input logic [7:0] cmd, input int n);
        host.open_frame();
        host.shift({8'h00, cmd, 16'h0000}, n);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // A hang counts as a mismatch
    initial
    begin
        #600000;
        mismatches++;
        give_verdict();
    end

    initial
    begin
        rst_n     = 1'b0;
        res_ready = 1'b0;
        v         = 12'h000;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (1250) @(negedge clk);
        chk({dout, busy, res_valid, irq_en, dout_oe_n}, 5'b00011);
        // Four addresses, every resolution, reference and power kind, leading zeros first
        foreach (cmds[i])
        begin
            v = vals[i];
            convert(cmds[i], 32);
            chk(host.rx, {16'h0000, rx_exp(cmds[i], vals[i])});
            chk({adc_power, irq_en}, {cmds[i][1:0] != 2'h0, cmds[i][1:0] == 2'h0});
            host.close_frame();
        end
        // Fill the buffer; the ninth start is refused
        v = 12'h123;
        for (int i = 0; i < 5; i++)
        begin
            convert(8'h90, 24);
            chk(host.rx[15:0], (i < 4) ? rx_exp(8'h90, 12'h123) : 16'h0000);
            host.close_frame();
        end
        // Drain, checking the decoded fields of the first four
        foreach (cmds[i])
        begin
            chk(res, {cmds[i][6:4], cmds[i][3], cmds[i][3] ? {vals[i][11:4], 4'h0} : vals[i]});
            res_ready = 1'b1;
            @(negedge clk);
            res_ready = 1'b0;
            @(negedge clk);
        end
        res_ready = 1'b1;
        repeat (8) @(negedge clk);
        chk({31'(pops), res_valid}, {31'd8, 1'b0});
        // Select high in mid conversion
        p0 = pops;
        host.open_frame();
        host.shift(32'h0000_0930, 12);
        host.close_frame();
        chk({31'(pops - p0), adc_power}, 32'h0);
        // Select held low, overlapped commands every 15 clocks
        p0 = pops;
        v  = 12'h9C3;
        host.open_frame();
        host.shift(32'h0, 16);
        host.shift({8'h90, 7'h00, 8'hDD, 9'h000}, 32);
        chk(host.rx, {9'h000, 12'h9C3, 3'h0, 8'h9C});
        host.close_frame();
        chk(pops - p0, 2);
        give_verdict();
    end
endmodule
